/* src/uhmp_pkg.sv */
// Constants and types for the dual-channel UART host access and modem pins
// ============================================================
package uhmp_pkg;
  // ============================================================
  // Bus map
  localparam int UHMP_ADDR_W = 12;
  localparam int UHMP_MAP_BITS = 6;
  localparam int UHMP_CH_BIT = 5;
  localparam int UHMP_IDX_LO = 2;
  localparam int UHMP_NUM_CH = 2;
  localparam logic [2:0] UHMP_IDX_HOLD = 3'h0;
  localparam logic [2:0] UHMP_IDX_FIFO_CTRL = 3'h2;
  localparam logic [2:0] UHMP_IDX_MODEM_CTRL = 3'h4;
  localparam logic [2:0] UHMP_IDX_LINE_STAT = 3'h5;
  localparam logic [2:0] UHMP_IDX_MODEM_STAT = 3'h6;
  localparam logic [2:0] UHMP_IDX_SCRATCH = 3'h7;
  localparam logic [1:0] UHMP_RESP_OKAY = 2'h0;
  localparam logic [1:0] UHMP_RESP_DECERR = 2'h3;
  localparam logic [23:0] UHMP_RDATA_PAD = 24'h000000;
  // ============================================================
  // Field positions
  localparam int UHMP_FCR_RX_CLR = 1;
  localparam int UHMP_FCR_TX_CLR = 2;
  localparam int UHMP_FCR_DMA = 3;
  localparam int UHMP_FCR_TRIG_LO = 6;
  localparam int UHMP_MCR_OP2 = 3;
  localparam int UHMP_LSR_DR = 0;
  localparam int UHMP_LSR_OVR = 1;
  localparam int UHMP_LSR_THRE = 5;
  localparam int UHMP_LSR_TEMT = 6;
  localparam int UHMP_MSR_CTS = 4;
  localparam int UHMP_MSR_DSR = 5;
  localparam int UHMP_MSR_RI = 6;
  localparam int UHMP_MSR_CD = 7;
  // ============================================================
  // Reset values and sizes
  localparam logic [7:0] UHMP_FCR_RST = 8'h00;
  localparam logic [7:0] UHMP_MCR_RST = 8'h00;
  localparam logic [7:0] UHMP_SCR_RST = 8'h00;
  localparam int UHMP_TRIG_L0 = 1;
  localparam int UHMP_TRIG_L1 = 4;
  localparam int UHMP_TRIG_L2 = 8;
  localparam int UHMP_TRIG_L3 = 14;
  localparam int UHMP_FIFO_DEPTH = 16;
  localparam int UHMP_OSC_PER_BIT = 16;
  localparam int UHMP_FRAME_BITS = 10;
  localparam int UHMP_DATA_BITS = 8;
  // ============================================================
  // State types
  typedef enum logic [1:0] {
    UHMP_TX_IDLE = 2'b00,
    UHMP_TX_FETCH = 2'b01,
    UHMP_TX_SHIFT = 2'b10
  } uhmp_tx_state_t;
  typedef enum logic [1:0] {
    UHMP_RX_IDLE = 2'b00,
    UHMP_RX_START = 2'b01,
    UHMP_RX_DATA = 2'b10,
    UHMP_RX_STOP = 2'b11
  } uhmp_rx_state_t;
endpackage

/* src/uhmp_mem.sv */
// Small two-port FIFO storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module uhmp_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    if (rd_en)
      rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

/* src/uhmp_top.sv */
// Dual-channel UART: AXI4-Lite register access, FIFOs, DMA ready and modem pins
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uhmp_top import uhmp_pkg::*; #(
  parameter int FIFO_DEPTH = UHMP_FIFO_DEPTH,
  parameter int OSC_PER_BIT = UHMP_OSC_PER_BIT,
  parameter int ADDR_W = UHMP_ADDR_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Oscillator
  input wire logic osc_clock_in,
  output logic osc_clock_out,
  // Channel A pins
  input wire logic rx_serial_ch_a,
  output logic tx_serial_ch_a,
  input wire logic cts_n_ch_a,
  input wire logic dsr_n_ch_a,
  input wire logic cd_n_ch_a,
  input wire logic ri_n_ch_a,
  output logic user_output_two_ch_a,
  output logic rx_ready_n_ch_a,
  output logic tx_ready_n_ch_a,
  // Channel B pins
  input wire logic rx_serial_ch_b,
  output logic tx_serial_ch_b,
  input wire logic cts_n_ch_b,
  input wire logic dsr_n_ch_b,
  input wire logic cd_n_ch_b,
  input wire logic ri_n_ch_b,
  output logic user_output_two_ch_b,
  output logic rx_ready_n_ch_b,
  output logic tx_ready_n_ch_b
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int TW = $clog2(OSC_PER_BIT);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(FIFO_DEPTH);
  localparam logic [PW:0] TRIG0 = (PW+1)'(UHMP_TRIG_L0);
  localparam logic [PW:0] TRIG1 = (PW+1)'(UHMP_TRIG_L1);
  localparam logic [PW:0] TRIG2 = (PW+1)'(UHMP_TRIG_L2);
  localparam logic [PW:0] TRIG3 = (PW+1)'(UHMP_TRIG_L3);
  localparam logic [TW-1:0] TK_LAST = TW'(OSC_PER_BIT-1);
  localparam logic [TW-1:0] TK_HALF = TW'(OSC_PER_BIT/2-1);
  localparam logic [3:0] TX_BIT_LAST = 4'(UHMP_FRAME_BITS-1);
  localparam logic [3:0] RX_BIT_LAST = 4'(UHMP_DATA_BITS-1);

  // ============================================================
  // Pin gathering
  wire [1:0] rx_pin = {rx_serial_ch_b, rx_serial_ch_a};
  wire [1:0] cts_n = {cts_n_ch_b, cts_n_ch_a};
  wire [1:0] dsr_n = {dsr_n_ch_b, dsr_n_ch_a};
  wire [1:0] cd_n = {cd_n_ch_b, cd_n_ch_a};
  wire [1:0] ri_n = {ri_n_ch_b, ri_n_ch_a};
  logic [1:0][7:0] ch_rdv;
  logic [1:0][7:0] rx_q;
  logic [1:0] rx_nonempty;
  logic [1:0] tx_pin;
  logic [1:0] op2_pin;
  logic [1:0] rxrdy_pin;
  logic [1:0] txrdy_pin;

  // ============================================================
  // Oscillator edge detect, bit timing reference
  logic osc_prev_r;
  logic osc_out_r;
  wire osc_tick = osc_clock_in && !osc_prev_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_prev_r <= 1'b1;
      osc_out_r <= 1'b0;
    end
    else
    begin
      osc_prev_r <= osc_clock_in;
      osc_out_r <= osc_clock_in;
    end
  end

  // ============================================================
  // AXI4-Lite slave
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic aw_have_r, w_have_r, w_strb0_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic rd_pend_r, rd_fifo_r, rd_ch_r;
  logic [1:0] bresp_r, rresp_r, rd_resp_r;
  logic [7:0] rd_hold_r, rdata_r;

  wire aw_take = awvalid && awready_r;
  wire w_take = wvalid && wready_r;
  wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
  wire aw_have_nxt = aw_take || (aw_have_r && !wr_fire);
  wire w_have_nxt = w_take || (w_have_r && !wr_fire);
  wire wr_ok = ~|aw_addr_r[ADDR_W-1:UHMP_MAP_BITS];
  wire wr_ch = aw_addr_r[UHMP_CH_BIT];
  wire [2:0] wr_idx = aw_addr_r[UHMP_CH_BIT-1:UHMP_IDX_LO];
  wire wr_en = wr_fire && wr_ok && w_strb0_r;
  wire ar_take = arvalid && arready_r;
  wire rd_ok = ~|araddr[ADDR_W-1:UHMP_MAP_BITS];
  wire rd_ch = araddr[UHMP_CH_BIT];
  wire [2:0] rd_idx = araddr[UHMP_CH_BIT-1:UHMP_IDX_LO];
  wire rd_en = ar_take && rd_ok;
  wire rvalid_nxt = rd_pend_r || (rvalid_r && !rready);
  wire rd_is_fifo = rd_ok && rd_idx == UHMP_IDX_HOLD && rx_nonempty[rd_ch];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 8'h00;
      w_strb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= UHMP_RESP_OKAY;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awready_r <= !aw_have_nxt;
      wready_r <= !w_have_nxt;
      if (aw_take)
        aw_addr_r <= awaddr;
      if (w_take)
      begin
        w_data_r <= wdata[7:0];
        w_strb0_r <= wstrb[0];
      end
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? UHMP_RESP_OKAY : UHMP_RESP_DECERR;
      end
      else if (bready)
        bvalid_r <= 1'b0;
    end
  end

  // Read data comes two cycles after the take so FIFO storage can answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rvalid_r <= 1'b0;
      rd_ch_r <= 1'b0;
      rd_fifo_r <= 1'b0;
      rd_hold_r <= 8'h00;
      rd_resp_r <= UHMP_RESP_OKAY;
      rdata_r <= 8'h00;
      rresp_r <= UHMP_RESP_OKAY;
    end
    else
    begin
      rd_pend_r <= ar_take;
      rvalid_r <= rvalid_nxt;
      arready_r <= !(ar_take || rvalid_nxt);
      if (ar_take)
      begin
        rd_ch_r <= rd_ch;
        rd_fifo_r <= rd_is_fifo;
        rd_hold_r <= rd_ok ? ch_rdv[rd_ch] : 8'h00;
        rd_resp_r <= rd_ok ? UHMP_RESP_OKAY : UHMP_RESP_DECERR;
      end
      if (rd_pend_r)
      begin
        rdata_r <= rd_fifo_r ? rx_q[rd_ch_r] : rd_hold_r;
        rresp_r <= rd_resp_r;
      end
    end
  end

  // ============================================================
  // Per-channel logic
  for (genvar g = 0; g < UHMP_NUM_CH; g++)
  begin : g_ch
    logic [7:0] fcr_r, mcr_r, scr_r;
    logic [PW:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
    logic ovr_r, op2_r, rxrdy_n_r, txrdy_n_r;
    uhmp_tx_state_t tx_st_r;
    uhmp_rx_state_t rx_st_r;
    logic [UHMP_FRAME_BITS-1:0] tx_sh_r;
    logic [7:0] rx_sh_r;
    logic [3:0] tx_bit_r, rx_bit_r;
    logic [TW-1:0] tx_tk_r, rx_tk_r;
    logic [7:0] tx_q;

    wire [PW:0] tx_cnt = tx_wp_r - tx_rp_r;
    wire [PW:0] rx_cnt = rx_wp_r - rx_rp_r;
    wire tx_full = tx_cnt == DEPTH_C;
    wire rx_full = rx_cnt == DEPTH_C;
    wire sel_w = wr_en && wr_ch == 1'(g);
    wire sel_r = rd_en && rd_ch == 1'(g);
    wire fcr_we = sel_w && wr_idx == UHMP_IDX_FIFO_CTRL;
    wire tx_push = sel_w && wr_idx == UHMP_IDX_HOLD && !tx_full;
    wire rx_pop = sel_r && rd_idx == UHMP_IDX_HOLD && rx_cnt != '0;
    wire ovr_clr = sel_r && rd_idx == UHMP_IDX_LINE_STAT;
    wire tx_clr = fcr_we && w_data_r[UHMP_FCR_TX_CLR];
    wire rx_clr = fcr_we && w_data_r[UHMP_FCR_RX_CLR];
    wire tx_load = tx_st_r == UHMP_TX_IDLE && tx_cnt != '0;
    wire tx_bit_end = osc_tick && tx_tk_r == TK_LAST;
    wire rx_end = osc_tick && rx_tk_r == TK_LAST;
    wire rx_half = osc_tick && rx_tk_r == TK_HALF;
    wire rx_done = rx_st_r == UHMP_RX_STOP && rx_end && rx_pin[g];
    wire rx_push = rx_done && !rx_full;
    wire ovr_set = rx_done && rx_full;
    wire [1:0] trig_sel = fcr_r[UHMP_FCR_TRIG_LO+1:UHMP_FCR_TRIG_LO];
    wire [PW:0] trig = trig_sel == 2'h0 ? TRIG0 : trig_sel == 2'h1 ? TRIG1 :
                       trig_sel == 2'h2 ? TRIG2 : TRIG3;
    wire dma1 = fcr_r[UHMP_FCR_DMA];
    wire rx_avail = dma1 ? rx_cnt >= trig : rx_cnt != '0;
    wire [7:0] lsr;
    wire [7:0] modem_status_reg;

    assign lsr = {1'b0, tx_cnt == '0 && tx_st_r == UHMP_TX_IDLE, tx_cnt == '0,
                  3'h0, ovr_r, rx_cnt != '0};
    // Modem inputs are status only; nothing below gates transmit or receive
    assign modem_status_reg = {!cd_n[g], !ri_n[g], !dsr_n[g], !cts_n[g], 4'h0};
    assign ch_rdv[g] = rd_idx == UHMP_IDX_FIFO_CTRL ? fcr_r :
                       rd_idx == UHMP_IDX_MODEM_CTRL ? mcr_r :
                       rd_idx == UHMP_IDX_LINE_STAT ? lsr :
                       rd_idx == UHMP_IDX_MODEM_STAT ? modem_status_reg :
                       rd_idx == UHMP_IDX_SCRATCH ? scr_r : 8'h00;
    assign rx_nonempty[g] = rx_cnt != '0;
    assign tx_pin[g] = tx_sh_r[0];
    assign op2_pin[g] = op2_r;
    assign rxrdy_pin[g] = rxrdy_n_r;
    assign txrdy_pin[g] = txrdy_n_r;

    uhmp_mem #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_mem (
      .clk(aclk),
      .wr_en(tx_push),
      .wr_addr(tx_wp_r[PW-1:0]),
      .wr_data(w_data_r),
      .rd_en(tx_load),
      .rd_addr(tx_rp_r[PW-1:0]),
      .rd_data(tx_q)
    );

    uhmp_mem #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_mem (
      .clk(aclk),
      .wr_en(rx_push),
      .wr_addr(rx_wp_r[PW-1:0]),
      .wr_data(rx_sh_r),
      .rd_en(rx_pop),
      .rd_addr(rx_rp_r[PW-1:0]),
      .rd_data(rx_q[g])
    );

    // Control registers, pointers and pin levels
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        fcr_r <= UHMP_FCR_RST;
        mcr_r <= UHMP_MCR_RST;
        scr_r <= UHMP_SCR_RST;
        tx_wp_r <= '0;
        tx_rp_r <= '0;
        rx_wp_r <= '0;
        rx_rp_r <= '0;
        ovr_r <= 1'b0;
        op2_r <= 1'b1;
        rxrdy_n_r <= 1'b1;
        txrdy_n_r <= 1'b1;
      end
      else
      begin
        if (fcr_we)
          fcr_r <= w_data_r;
        if (sel_w && wr_idx == UHMP_IDX_MODEM_CTRL)
          mcr_r <= w_data_r;
        if (sel_w && wr_idx == UHMP_IDX_SCRATCH)
          scr_r <= w_data_r;
        tx_wp_r <= tx_clr ? '0 : tx_wp_r + (PW+1)'(tx_push);
        tx_rp_r <= tx_clr ? '0 : tx_rp_r + (PW+1)'(tx_load);
        rx_wp_r <= rx_clr ? '0 : rx_wp_r + (PW+1)'(rx_push);
        rx_rp_r <= rx_clr ? '0 : rx_rp_r + (PW+1)'(rx_pop);
        // Overrun set wins over the clear caused by a status read
        ovr_r <= ovr_set || (ovr_r && !ovr_clr);
        op2_r <= !mcr_r[UHMP_MCR_OP2];
        rxrdy_n_r <= !rx_avail;
        txrdy_n_r <= tx_full;
      end
    end

    // Transmitter: 1 start, 8 data LSB first, 1 stop
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        tx_st_r <= UHMP_TX_IDLE;
        tx_sh_r <= '1;
        tx_bit_r <= 4'h0;
        tx_tk_r <= '0;
      end
      else
      begin
        case (tx_st_r)
          UHMP_TX_IDLE:
            if (tx_load)
              tx_st_r <= UHMP_TX_FETCH;
          UHMP_TX_FETCH:
          begin
            tx_sh_r <= {1'b1, tx_q, 1'b0};
            tx_bit_r <= 4'h0;
            tx_tk_r <= '0;
            tx_st_r <= UHMP_TX_SHIFT;
          end
          UHMP_TX_SHIFT:
            if (osc_tick)
            begin
              tx_tk_r <= tx_bit_end ? '0 : tx_tk_r + 1'b1;
              if (tx_bit_end)
              begin
                tx_sh_r <= {1'b1, tx_sh_r[UHMP_FRAME_BITS-1:1]};
                tx_bit_r <= tx_bit_r + 4'h1;
                if (tx_bit_r == TX_BIT_LAST)
                  tx_st_r <= UHMP_TX_IDLE;
              end
            end
          default:
            tx_st_r <= UHMP_TX_IDLE;
        endcase
      end
    end

    // Receiver: start bit checked at mid-bit, then one sample per bit
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        rx_st_r <= UHMP_RX_IDLE;
        rx_sh_r <= 8'h00;
        rx_bit_r <= 4'h0;
        rx_tk_r <= '0;
      end
      else
      begin
        case (rx_st_r)
          UHMP_RX_IDLE:
            if (osc_tick && !rx_pin[g])
            begin
              rx_tk_r <= '0;
              rx_st_r <= UHMP_RX_START;
            end
          UHMP_RX_START:
            if (rx_half)
            begin
              rx_tk_r <= '0;
              rx_bit_r <= 4'h0;
              // A start bit that is gone by mid-bit is taken as a glitch
              rx_st_r <= rx_pin[g] ? UHMP_RX_IDLE : UHMP_RX_DATA;
            end
            else if (osc_tick)
              rx_tk_r <= rx_tk_r + 1'b1;
          UHMP_RX_DATA:
            if (osc_tick)
            begin
              rx_tk_r <= rx_end ? '0 : rx_tk_r + 1'b1;
              if (rx_end)
              begin
                rx_sh_r <= {rx_pin[g], rx_sh_r[7:1]};
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == RX_BIT_LAST)
                  rx_st_r <= UHMP_RX_STOP;
              end
            end
          UHMP_RX_STOP:
            if (osc_tick)
            begin
              rx_tk_r <= rx_end ? '0 : rx_tk_r + 1'b1;
              if (rx_end)
                rx_st_r <= UHMP_RX_IDLE;
            end
          default:
            rx_st_r <= UHMP_RX_IDLE;
        endcase
      end
    end
  end

  // ============================================================
  // Outputs
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = {UHMP_RDATA_PAD, rdata_r};
  assign osc_clock_out = osc_out_r;
  assign tx_serial_ch_a = tx_pin[0];
  assign tx_serial_ch_b = tx_pin[1];
  assign user_output_two_ch_a = op2_pin[0];
  assign user_output_two_ch_b = op2_pin[1];
  assign rx_ready_n_ch_a = rxrdy_pin[0];
  assign rx_ready_n_ch_b = rxrdy_pin[1];
  assign tx_ready_n_ch_a = txrdy_pin[0];
  assign tx_ready_n_ch_b = txrdy_pin[1];
endmodule
`default_nettype wire

/* tb/uhmp_checker.sv */
// Port-level assertions for the dual-channel UART block
`timescale 1ns/1ps
`default_nettype none
module uhmp_checker import uhmp_pkg::*; #(
  parameter int ADDR_W = UHMP_ADDR_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Pins
  input wire logic cts_n_ch_a,
  input wire logic dsr_n_ch_a,
  input wire logic cd_n_ch_a,
  input wire logic tx_serial_ch_a,
  input wire logic tx_serial_ch_b,
  input wire logic user_output_two_ch_a,
  input wire logic user_output_two_ch_b,
  input wire logic rx_ready_n_ch_a,
  input wire logic rx_ready_n_ch_b,
  input wire logic tx_ready_n_ch_a,
  input wire logic tx_ready_n_ch_b
);
  // ============================================================
  // Helper decode
  wire logic ar_bad = |araddr[ADDR_W-1:6];
  wire logic aw_ok = !(|awaddr[ADDR_W-1:6]) && wstrb[0];
  wire logic mcr_a = aw_ok && awaddr[5:0] == 6'h10;
  wire logic mcr_b = aw_ok && awaddr[5:0] == 6'h30;
  logic rd_bad_r;
  logic rd_msr_r;
  // Kind of the pending read; its answer comes later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_bad_r <= 1'h0;
      rd_msr_r <= 1'h0;
    end
    else if (arvalid && arready)
    begin
      rd_bad_r <= ar_bad;
      rd_msr_r <= !ar_bad && araddr[5:0] == 6'h18;
    end
  end
  // ============================================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_fire_s;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take_s;
    arvalid && arready;
  endsequence
  a_reset_pins: assert property ($rose(aresetn) |-> user_output_two_ch_a
    && user_output_two_ch_b && tx_serial_ch_a && tx_serial_ch_b && rx_ready_n_ch_a
    && rx_ready_n_ch_b && tx_ready_n_ch_a && tx_ready_n_ch_b && !bvalid && !rvalid)
    else $error("outputs not at reset level");
  a_write_answer: assert property (wr_fire_s |-> ##[1:3] bvalid)
    else $error("write not answered");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_answer: assert property (rd_take_s |-> ##[1:3] rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_resp_decode: assert property (rvalid |-> rdata[31:8] == UHMP_RDATA_PAD
    && rresp == (rd_bad_r ? UHMP_RESP_DECERR : UHMP_RESP_OKAY))
    else $error("read response wrong");
  a_user_out_low: assert property (wr_fire_s ##0 (mcr_a && wdata[3])
    |-> ##[1:4] !user_output_two_ch_a) else $error("user output A not low");
  a_user_out_high: assert property (wr_fire_s ##0 (mcr_b && !wdata[3])
    |-> ##[1:4] user_output_two_ch_b) else $error("user output B not high");
  a_status_bits: assert property (rvalid && rd_msr_r |-> rdata[7] == !cd_n_ch_a
    && rdata[5] == !dsr_n_ch_a && rdata[4] == !cts_n_ch_a)
    else $error("modem status bits wrong");
endmodule
bind uhmp_top uhmp_checker #(.ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn, .awaddr, .awvalid,
  .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
  .arready, .rdata, .rresp, .rvalid, .rready, .cts_n_ch_a, .dsr_n_ch_a, .cd_n_ch_a,
  .tx_serial_ch_a, .tx_serial_ch_b, .user_output_two_ch_a, .user_output_two_ch_b,
  .rx_ready_n_ch_a, .rx_ready_n_ch_b, .tx_ready_n_ch_a, .tx_ready_n_ch_b);
`default_nettype wire

/* tb/uhmp_modem.sv */
// Modem and oscillator model beyond both channels
`timescale 1ns/1ps
`default_nettype none
module uhmp_modem (
  // Clock
  input wire logic aclk,
  // Wanted pin levels {cd, ri, dsr, cts}, active low
  input wire logic [3:0] st_a,
  input wire logic [3:0] st_b,
  // Serial lines from the device
  input wire logic tx_a,
  input wire logic tx_b,
  // Lines toward the device
  output logic osc,
  output logic rx_a,
  output logic rx_b,
  output logic [3:0] pin_a,
  output logic [3:0] pin_b
);
  logic [1:0] div_r = 2'h0;
  logic [1:0] rx_r = 2'h3;
  logic [3:0] pa_r = 4'hF;
  logic [3:0] pb_r = 4'hF;
  // Modem loops each line back, so the receiver sees real frames
  always_ff @(posedge aclk)
  begin
    div_r <= div_r + 2'h1;
    rx_r <= {tx_b, tx_a};
    pa_r <= st_a;
    pb_r <= st_b;
  end
  assign osc = div_r[1];
  assign rx_a = rx_r[0];
  assign rx_b = rx_r[1];
  assign pin_a = pa_r;
  assign pin_b = pb_r;
endmodule
`default_nettype wire

/* tb/test_uart_host_and_modem_pins.sv */
// Self-checking bench for the dual-channel UART block
`timescale 1ns/1ps
`default_nettype none
module test_uart_host_and_modem_pins import uhmp_pkg::*; ();
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid, osc_out;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [3:0] wstrb = 4'h0, st_a = 4'hF, st_b = 4'hF, pa, pb;
  logic [1:0] bresp, rresp;
  logic osc, rx_serial_ch_a, rx_serial_ch_b, tx_serial_ch_a, tx_serial_ch_b;
  logic user_output_two_ch_a, user_output_two_ch_b, rx_ready_n_ch_a, rx_ready_n_ch_b;
  logic tx_ready_n_ch_a, tx_ready_n_ch_b;
  int n_fail = 0, cmp_count = 0;
  uhmp_top #(.OSC_PER_BIT(4)) dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .osc_clock_in(osc), .osc_clock_out(osc_out), .rx_serial_ch_a, .tx_serial_ch_a,
    .cts_n_ch_a(pa[0]), .dsr_n_ch_a(pa[1]), .ri_n_ch_a(pa[2]), .cd_n_ch_a(pa[3]),
    .user_output_two_ch_a, .rx_ready_n_ch_a, .tx_ready_n_ch_a, .rx_serial_ch_b,
    .tx_serial_ch_b, .cts_n_ch_b(pb[0]), .dsr_n_ch_b(pb[1]), .ri_n_ch_b(pb[2]),
    .cd_n_ch_b(pb[3]), .user_output_two_ch_b, .rx_ready_n_ch_b, .tx_ready_n_ch_b);
  uhmp_modem u_modem (.aclk, .st_a, .st_b, .tx_a(tx_serial_ch_a), .tx_b(tx_serial_ch_b),
    .osc, .rx_a(rx_serial_ch_a), .rx_b(rx_serial_ch_b), .pin_a(pa), .pin_b(pb));
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  // ============================================================
  // Reporting and bus tasks
  task automatic tally_and_finish;
    $display("TB: comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic guard(input int n);
    if (n > 2000)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever
    begin
      @(posedge aclk);
      n++;
      guard(n);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'h0;
        return;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever
    begin
      @(posedge aclk);
      n++;
      guard(n);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid)
      begin
        d = rdata[7:0];
        r = rresp;
        rready <= 1'h0;
        return;
      end
    end
  endtask
  task automatic wr_ok(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("bresp", r, UHMP_RESP_OKAY);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check("rdata", d, e);
    check("rresp", r, UHMP_RESP_OKAY);
  endtask
  task automatic wait_rx;
    int n;
    n = 0;
    while (rx_ready_n_ch_a !== 1'h0)
    begin
      @(posedge aclk);
      n++;
      guard(n);
    end
  endtask
  // Transmitter fully idle means looped frames have landed
  task automatic wait_idle;
    logic [7:0] d;
    logic [1:0] r;
    int k;
    k = 0;
    d = 8'h00;
    while (!d[6])
    begin
      rd(12'h014, d, r);
      k++;
      guard(k * 10);
    end
  endtask
  // ============================================================
  // Scenarios
  task automatic s_reset;
    logic o;
    check("uo_a", user_output_two_ch_a, 8'h01);
    check("uo_b", user_output_two_ch_b, 8'h01);
    check("tx_a", tx_serial_ch_a, 8'h01);
    check("rr_a", rx_ready_n_ch_a, 8'h01);
    check("tr_b", tx_ready_n_ch_b, 8'h00);
    o = osc;
    @(posedge aclk);
    check("osc_out", osc_out, o);
    rd_chk(12'h008, UHMP_FCR_RST);
    rd_chk(12'h030, UHMP_MCR_RST);
    rd_chk(12'h01C, UHMP_SCR_RST);
  endtask
  task automatic s_user_out;
    wr_ok(12'h010, 8'h08);
    repeat (2) @(posedge aclk);
    check("uo_a", user_output_two_ch_a, 8'h00);
    check("uo_b", user_output_two_ch_b, 8'h01);
    wr_ok(12'h030, 8'h08);
    wr_ok(12'h010, 8'h00);
    repeat (2) @(posedge aclk);
    check("uo_a", user_output_two_ch_a, 8'h01);
    check("uo_b", user_output_two_ch_b, 8'h00);
    rd_chk(12'h030, 8'h08);
    wr_ok(12'h030, 8'h00);
  endtask
  task automatic s_status;
    for (int i = 0; i < 2; i++)
    begin
      st_a <= i[0] ? 4'hA : 4'h5;
      st_b <= i[0] ? 4'h5 : 4'hA;
      repeat (3) @(posedge aclk);
      rd_chk(12'h018, {~st_a, 4'h0});
      rd_chk(12'h038, {~st_b, 4'h0});
    end
  endtask
  task automatic s_decerr;
    logic [7:0] d;
    logic [1:0] r;
    wr_ok(12'h01C, 8'h5A);
    wr(12'h05C, 8'hA5, r);
    check("bresp", r, UHMP_RESP_DECERR);
    rd(12'h05C, d, r);
    check("rresp", r, UHMP_RESP_DECERR);
    rd_chk(12'h01C, 8'h5A);
    rd_chk(12'h03C, UHMP_SCR_RST);
  endtask
  task automatic s_tx_full;
    int k;
    k = 0;
    wr_ok(12'h008, 8'h0C);
    while (tx_ready_n_ch_a === 1'h0 && k < 20)
    begin
      wr_ok(12'h000, k[7:0]);
      k++;
      repeat (2) @(posedge aclk);
    end
    check("tr_a", tx_ready_n_ch_a, 8'h01);
    check("fill", 8'(k >= 16 && k <= 17), 8'h01);
    check("tr_b", tx_ready_n_ch_b, 8'h00);
    wr_ok(12'h008, 8'h04);
    repeat (2) @(posedge aclk);
    check("tr_a", tx_ready_n_ch_a, 8'h00);
    wait_idle();
  endtask
  task automatic s_rx;
    wr_ok(12'h008, 8'h02);
    st_a <= 4'hF;
    repeat (2) @(posedge aclk);
    check("rr_a", rx_ready_n_ch_a, 8'h01);
    wr_ok(12'h000, 8'hC3);
    wait_rx();
    check("rr_a", rx_ready_n_ch_a, 8'h00);
    rd_chk(12'h000, 8'hC3);
    repeat (2) @(posedge aclk);
    check("rr_a", rx_ready_n_ch_a, 8'h01);
    wr_ok(12'h008, 8'h4A);
    for (int i = 0; i < 3; i++)
      wr_ok(12'h000, 8'h30 + i[7:0]);
    wait_idle();
    check("rr_a", rx_ready_n_ch_a, 8'h01);
    wr_ok(12'h000, 8'h33);
    wait_rx();
    check("rr_a", rx_ready_n_ch_a, 8'h00);
    for (int i = 0; i < 4; i++)
      rd_chk(12'h000, 8'h30 + i[7:0]);
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    s_reset();
    s_user_out();
    s_status();
    s_decerr();
    s_tx_full();
    s_rx();
    tally_and_finish();
  end
endmodule
`default_nettype wire
